// ==== design/qtcp_edge_sync.sv ====
`timescale 1ns/1ps
module qtcp_edge_sync (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic pin_i,
	output logic rise_o,
	output logic fall_o
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// Two-stage synchroniser, then one more stage for edges
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Edges only from settled stages
	assign rise_o = sync_reg & ~prev_reg;
	assign fall_o = ~sync_reg & prev_reg;

	a_edge_single: assert property (@(posedge clk_i) disable iff (!arst_n_i) rise_o |=> !rise_o)
		else $error("rise pulse longer than one cycle");
endmodule

// ==== design/qtcp_quad_timer.sv ====
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module qtcp_quad_timer (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [qtcp_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [qtcp_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [qtcp_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [1:0] event_input_pin_i,
	input wire logic [3:0] ext_irq_input_i,
	output logic compare_pwm_out_pin_o,
	output logic compare_pwm_out_oe_n_o
);
	import qtcp_pkg::*;

	logic wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [7:0] mode_reg [4];
	logic [7:0] data_reg [4];
	logic [7:0] cnt_reg [4];
	logic [7:0] cap_reg [4];
	logic [7:0] per_low_reg;
	logic [7:0] duty_low_reg;
	logic [3:0] hi_reg;
	logic [2:0] pfunc_reg;
	logic [7:0] edge_sel_reg;
	logic [7:0] flags_reg;
	logic [PRE_W-1:0] pre_reg;
	logic [9:0] pwm_cnt_reg;
	logic [9:0] duty_act_reg;
	logic out_reg;
	logic oe_n_reg;

	logic [1:0] ev_rise;
	logic [3:0] ext_rise;
	logic [3:0] ext_fall;
	logic [3:0] edge_hit;
	logic [3:0] tick;
	logic [3:0] adv;
	logic [3:0] inc;
	logic [3:0] match;
	logic [3:0] wrap;
	logic [3:0] cap_en;
	logic [3:0] cap_trig;
	logic [3:0] flag_set;
	logic [3:0] wr_tmr;
	logic [1:0] pair;
	logic [1:0] match16;

	// Bus handshake: first edge latches read data, second edge completes
	wire bus_req = avs_read_i | avs_write_i;
	wire bus_take = bus_req & wait_reg;
	wire bus_done = bus_req & ~wait_reg;
	wire wr_acc = bus_done & avs_write_i & avs_byteenable_i[0];
	wire [7:0] wbyte = avs_writedata_i[7:0];
	wire in_tmr = ~avs_address_i[4];
	wire [1:0] tsel = avs_address_i[3:2];
	wire [1:0] toff = avs_address_i[1:0];
	wire wr_misc = wr_acc & ~in_tmr;
	wire wr_per = wr_misc & (avs_address_i == OFF_PWM_PER);
	wire wr_duty = wr_misc & (avs_address_i == OFF_PWM_DUTY);
	wire wr_hi = wr_misc & (avs_address_i == OFF_PWM_HI);
	wire wr_pf = wr_misc & (avs_address_i == OFF_PORT_FUNC);
	wire wr_es = wr_misc & (avs_address_i == OFF_EDGE_SEL);
	wire wr_fl = wr_misc & (avs_address_i == OFF_FLAGS);
	wire wait_next = ~bus_take;

	// shared read picks capture or count
	// count read back where data is written
	wire [7:0] shared_rd = cap_en[tsel] ? cap_reg[tsel] : cnt_reg[tsel];
	wire [7:0] rd_tmr = (toff == OFF_MODE) ? mode_reg[tsel] :
		(toff == OFF_CNT) ? shared_rd :
		(toff == OFF_CAP) ? cap_reg[tsel] : data_reg[tsel];
	wire [7:0] rd_misc = (avs_address_i == OFF_PWM_PER) ? per_low_reg :
		(avs_address_i == OFF_PWM_DUTY) ? duty_low_reg :
		(avs_address_i == OFF_PWM_HI) ? {4'h0, hi_reg} :
		(avs_address_i == OFF_PORT_FUNC) ? {5'h00, pfunc_reg} :
		(avs_address_i == OFF_EDGE_SEL) ? edge_sel_reg :
		(avs_address_i == OFF_FLAGS) ? flags_reg : 8'h00;
	wire [DATA_W-1:0] rd_word = {24'h000000, in_tmr ? rd_tmr : rd_misc};
	wire [DATA_W-1:0] rdata_next = bus_take ? rd_word : rdata_reg;

	// Bus state; unmapped reads give zero, unmapped writes are dropped
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end
	assign avs_waitrequest_o = wait_reg;
	assign avs_readdata_o = rdata_reg;

	// Free-running prescaler shared by all timers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_reg <= 11'h000;
		end else begin
			pre_reg <= pre_reg + 11'h001;
		end
	end

	// Event pins, only the even timers get one
	genvar i;
	for (i = 0; i < 2; i++) begin : g_ev
		qtcp_edge_sync u_ev (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.pin_i(event_input_pin_i[i]),
			.rise_o(ev_rise[i]),
			.fall_o()
		);
	end

	// Capture inputs with programmable edge
	for (i = 0; i < 4; i++) begin : g_ext
		qtcp_edge_sync u_ext (
			.clk_i(clk_i),
			.arst_n_i(arst_n_i),
			.pin_i(ext_irq_input_i[i]),
			.rise_o(ext_rise[i]),
			.fall_o(ext_fall[i])
		);
		assign edge_hit[i] = (edge_sel_reg[2*i+ES_FALL] & ext_fall[i]) |
			(edge_sel_reg[2*i+ES_RISE] & ext_rise[i]);
	end

	// PWM controls, needed by timer 3 gating
	wire pwm_mode = mode_reg[3][MB_PWM_EN] & pfunc_reg[PF_PWM];

	// Pair-level match of the 16-bit counter
	for (i = 0; i < 2; i++) begin : g_pair
		assign pair[i] = mode_reg[2*i+1][MB_PAIR];
		assign match16[i] = {cnt_reg[2*i+1], cnt_reg[2*i]} == {data_reg[2*i+1], data_reg[2*i]};
	end

	genvar t;
	for (t = 0; t < 4; t++) begin : g_tmr
		localparam int P = t / 2;
		localparam int E = 2 * P;
		logic [7:0] cnt_next;
		logic [7:0] cnt_inc;

		if (t % 2 == 0) begin : g_even
			wire [PRE_W-1:0] msk = even_mask(mode_reg[t][2:0]);
			wire ev_sel = mode_reg[t][2:0] == CK_EVENT;
			// prescaled tick when mask bits all set
			assign tick[t] = ev_sel ? (ev_rise[P] & pfunc_reg[PF_EV0+P]) : ((pre_reg & msk) == msk);
			assign adv[t] = tick[t] & mode_reg[t][MB_RUN];
			assign inc[t] = adv[t];
			assign cap_en[t] = mode_reg[t][MB_CAP];
			assign cap_trig[t] = cap_en[t] & edge_hit[t];
			// even flag serves the whole pair
			assign flag_set[t] = wrap[t];
		end else begin : g_odd
			wire [PRE_W-1:0] msk = odd_mask(mode_reg[t][1:0]);
			// unpaired odd timers never see an event pin
			// paired half takes the even clock and carry
			assign tick[t] = pair[P] ? tick[E] : ((pre_reg & msk) == msk);
			assign adv[t] = pair[P] ? adv[E] : (tick[t] & mode_reg[t][MB_RUN] & ~((t == 3) & pwm_mode));
			assign inc[t] = pair[P] ? (adv[E] & (cnt_reg[E] == 8'hff)) : adv[t];
			// paired capture follows the even controls
			assign cap_en[t] = pair[P] ? mode_reg[E][MB_CAP] : mode_reg[t][MB_CAP];
			assign cap_trig[t] = cap_en[t] & (pair[P] ? edge_hit[E] : edge_hit[t]);
			assign flag_set[t] = wrap[t] & ~pair[P];
		end

		assign match[t] = pair[P] ? match16[P] : (cnt_reg[t] == data_reg[t]);
		// match on a counting tick wraps to zero
		// capture mode keeps the same wrap
		assign wrap[t] = adv[t] & match[t];
		assign wr_tmr[t] = wr_acc & in_tmr & (tsel == 2'(t));
		assign cnt_inc = cnt_reg[t] + 8'h01;
		// capture clears the count, wins over ticking
		assign cnt_next = cap_trig[t] ? CNT_RST : wrap[t] ? CNT_RST : inc[t] ? cnt_inc : cnt_reg[t];

		// Per-timer storage; capture copies the count before clearing
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				mode_reg[t] <= MODE_RST;
				data_reg[t] <= DATA_RST;
				cnt_reg[t] <= CNT_RST;
				cap_reg[t] <= CNT_RST;
			end else begin
				cnt_reg[t] <= cnt_next;
				if (cap_trig[t]) begin
					cap_reg[t] <= cnt_reg[t];
				end
				if (wr_tmr[t] && toff == OFF_MODE) begin
					mode_reg[t] <= wbyte;
				end
				if (wr_tmr[t] && (toff == OFF_CNT || toff == OFF_DATA)) begin
					data_reg[t] <= wbyte;
				end
			end
		end
	end

	// Sticky flags: write one clears, a same-cycle event still sets
	wire [7:0] flag_clr = wr_fl ? wbyte : 8'h00;
	wire [7:0] flag_new = {edge_hit, flag_set};
	wire [7:0] flags_next = (flags_reg & ~flag_clr) | flag_new;

	// Shared configuration registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			per_low_reg <= PER_RST;
			duty_low_reg <= DUTY_RST;
			hi_reg <= HI_RST;
			pfunc_reg <= PF_RST;
			edge_sel_reg <= ES_RST;
			flags_reg <= FLAG_RST;
		end else begin
			if (wr_per) per_low_reg <= wbyte;
			if (wr_duty) duty_low_reg <= wbyte;
			if (wr_hi) hi_reg <= wbyte[3:0];
			if (wr_pf) pfunc_reg <= wbyte[2:0];
			if (wr_es) edge_sel_reg <= wbyte;
			flags_reg <= flags_next;
		end
	end

	// 10-bit period and duty from high bits over low
	wire [9:0] pwm_per = {hi_reg[HI_PER_LSB+1:HI_PER_LSB], per_low_reg};
	wire [9:0] duty_master = {hi_reg[HI_DUTY_LSB+1:HI_DUTY_LSB], duty_low_reg};
	wire pwm_pol = mode_reg[3][MB_POL];
	// PWM counts only with timer 3 running
	wire pwm_tick = tick[3] & mode_reg[3][MB_RUN];
	// Greater-or-equal so a shortened period cannot run away
	wire pwm_end = pwm_tick & (pwm_cnt_reg >= pwm_per);
	wire [9:0] pwm_inc = pwm_cnt_reg + 10'h001;
	wire [9:0] pwm_cnt_next = (~pwm_mode | pwm_end) ? 10'h000 : pwm_tick ? pwm_inc : pwm_cnt_reg;
	// active duty reloads at period end, and every cycle while PWM is off
	wire [9:0] duty_act_next = (~pwm_mode | pwm_end) ? duty_master : duty_act_reg;
	// polarity sets duty level; zero duty is the inverse
	wire pwm_level = (duty_act_reg == 10'h000) ? ~pwm_pol : (pwm_cnt_reg <= duty_act_reg) ? pwm_pol : ~pwm_pol;

	// compare match of timer 2 or pair 2/3 toggles
	wire cmp_toggle = wrap[2];
	// PWM owns the pin when both bits are set
	wire out_next = ~pfunc_reg[PF_PWM] ? 1'b0 : pwm_mode ? pwm_level : cmp_toggle ? ~out_reg : out_reg;
	wire oe_n_next = ~pfunc_reg[PF_PWM];

	// PWM counter and pin flops; pin idles low when not selected
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwm_cnt_reg <= 10'h000;
			duty_act_reg <= 10'h000;
			out_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			pwm_cnt_reg <= pwm_cnt_next;
			duty_act_reg <= duty_act_next;
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end
	assign compare_pwm_out_pin_o = out_reg;
	assign compare_pwm_out_oe_n_o = oe_n_reg;

	// Checks on the counting, capture and PWM paths
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_match_wrap: assert property (wrap[0] && !cap_trig[0] |=> cnt_reg[0] == 8'h00)
		else $error("timer 0 did not wrap on match");
	a_match_flag: assert property (wrap[0] && !pair[0] |=> flags_reg[0])
		else $error("timer 0 flag not set on match");
	a_count_step: assert property (adv[1] && !match[1] && !cap_trig[1] && !pair[0]
		|=> cnt_reg[1] == $past(cnt_reg[1]) + 8'h01)
		else $error("timer 1 did not advance by one");
	a_event_only: assert property (mode_reg[0][2:0] == CK_EVENT && !ev_rise[0] && !cap_trig[0]
		|=> $stable(cnt_reg[0]))
		else $error("event count moved without a pin edge");
	a_odd_silent: assert property (pair[0] && wrap[0] && !flags_reg[1]
		|=> !flags_reg[1])
		else $error("odd timer flag set while paired");
	a_pair_carry: assert property (pair[0] && adv[0] && !match16[0] && !cap_trig[0] && cnt_reg[0] == 8'hff
		|=> cnt_reg[0] == 8'h00 && cnt_reg[1] == $past(cnt_reg[1]) + 8'h01)
		else $error("16-bit carry lost");
	a_capture_copy: assert property (cap_trig[0] |=> cap_reg[0] == $past(cnt_reg[0]) && cnt_reg[0] == 8'h00)
		else $error("capture did not copy and clear");
	a_edge_flag: assert property (edge_hit[0] |=> flags_reg[FL_EXT_LSB])
		else $error("capture edge flag missing");
	a_shared_read: assert property (bus_take && avs_read_i && avs_address_i == {3'h0, OFF_CNT}
		|=> avs_readdata_o[7:0] == ($past(cap_en[0]) ? $past(cap_reg[0]) : $past(cnt_reg[0])))
		else $error("shared read returned the wrong register");
	a_cmp_toggle: assert property (cmp_toggle && pfunc_reg[PF_PWM] && !pwm_mode
		|=> compare_pwm_out_pin_o != $past(compare_pwm_out_pin_o))
		else $error("compare match did not toggle the pin");
	a_duty_load: assert property (pwm_mode && pwm_end |=> duty_act_reg == $past(duty_master))
		else $error("duty not reloaded at period end");
	a_duty_hold: assert property (pwm_mode && !pwm_end |=> $stable(duty_act_reg))
		else $error("duty changed inside a period");
	a_full_duty: assert property (pwm_mode && duty_act_reg != 10'h000 && pwm_cnt_reg <= duty_act_reg
		|=> compare_pwm_out_pin_o == $past(pwm_pol))
		else $error("PWM duty phase has wrong level");
	a_bus_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");

	c_pair_wrap: cover property (pair[0] && wrap[0]);
	c_capture: cover property (cap_trig[0] && cnt_reg[0] != 8'h00);
	c_pwm_period: cover property (pwm_mode && pwm_end);
	c_cmp_toggle: cover property (cmp_toggle && pfunc_reg[PF_PWM] && !pwm_mode);
endmodule

// ==== dv/qtcp_pin_model.sv ====
`timescale 1ns/1ps
// Far-side pins: event sources, capture sources and an observer of the output pin
module qtcp_pin_model (
	input wire logic clk_i,
	input wire logic pwm_pin_i,
	output logic [1:0] event_pin_o,
	output logic [3:0] capture_pin_o
);
	initial begin
		event_pin_o = 2'h0;
		capture_pin_o = 4'h0;
	end

	// event pin used as a plain input, held long enough for the synchroniser
	task automatic pulse_event(input int n, input int cnt);
		repeat (cnt) begin
			@(posedge clk_i);
			event_pin_o[n] <= 1'b1;
			repeat (4) @(posedge clk_i);
			event_pin_o[n] <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask

	// One pulse gives a rising and then a falling edge on a capture input
	task automatic pulse_capture(input int n);
		@(posedge clk_i);
		capture_pin_o[n] <= 1'b1;
		repeat (6) @(posedge clk_i);
		capture_pin_o[n] <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask

	// High time and period in cycles; both zero if the pin never rises
	task automatic measure(output int hi, output int per);
		int k;
		hi = 0;
		per = 0;
		k = 0;
		while (pwm_pin_i !== 1'b0 && k < 100) begin
			@(posedge clk_i);
			k++;
		end
		while (pwm_pin_i !== 1'b1 && k < 200) begin
			@(posedge clk_i);
			k++;
		end
		while (pwm_pin_i === 1'b1 && k < 300) begin
			@(posedge clk_i);
			hi++;
			k++;
		end
		per = hi;
		while (pwm_pin_i === 1'b0 && k < 400 && hi > 0) begin
			@(posedge clk_i);
			per++;
			k++;
		end
	endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import qtcp_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [ADDR_W-1:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wdat = '0;
	logic [DATA_W-1:0] rdat;
	logic wait_q;
	logic [1:0] ev;
	logic [3:0] cap;
	logic pin;
	logic oe_n;
	int err_count = 0;
	int n_tests = 0;

	// 250 MHz clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	qtcp_quad_timer i_qtcp_quad_timer (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_q), .event_input_pin_i(ev),
		.ext_irq_input_i(cap), .compare_pwm_out_pin_o(pin), .compare_pwm_out_oe_n_o(oe_n));
	qtcp_pin_model i_qtcp_pin_model (.clk_i(clk_i), .pwm_pin_i(pin), .event_pin_o(ev), .capture_pin_o(cap));

	task automatic complete_run();
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low; one edge gap between requests
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		adr <= a;
		wdat <= {24'h0, d};
		wr <= w;
		rd <= ~w;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wait_q !== 1'b0 && k < 50);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (k >= 50) begin
			err_count++;
			complete_run();
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check(q, {24'h0, e});
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		arst_n_i <= 1'b1;
	endtask

	task automatic t_reset_values();
		logic [4:0] a[10] = '{5'h00, 5'h01, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1f};
		logic [7:0] e[10] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		do_reset();
		for (int i = 0; i < 10; i++) begin
			rd_chk(a[i], e[i]);
		end
		check({31'h0, oe_n}, 32'h1);
		$display("test reset_values done");
	endtask

	// Match wrap, sticky flag, a frozen count once stopped, timer 1 stepping alone
	task automatic t_match();
		logic [31:0] q;
		logic [31:0] q2;
		do_reset();
		wr_reg(5'h01, 8'h02);
		rd_chk(5'h03, 8'h02);
		// timer 1 alone at /8, no capture, no pairing
		wr_reg(5'h04, 8'h12);
		wr_reg(5'h00, 8'h10);
		repeat (30) @(posedge clk_i);
		rd_chk(5'h15, 8'h01);
		bus(1'b0, 5'h01, 8'h00, q);
		check({31'h0, q <= 32'h2}, 32'h1);
		wr_reg(5'h00, 8'h00);
		wr_reg(5'h15, 8'h01);
		rd_chk(5'h15, 8'h00);
		bus(1'b0, 5'h01, 8'h00, q);
		repeat (20) @(posedge clk_i);
		bus(1'b0, 5'h01, 8'h00, q2);
		check(q2, q);
		// Two latches 64 cycles apart must see exactly 8 ticks at /8
		bus(1'b0, 5'h05, 8'h00, q);
		repeat (61) @(posedge clk_i);
		bus(1'b0, 5'h05, 8'h00, q2);
		check(q2 - q, 32'h8);
		$display("test match done");
	endtask

	task automatic t_event_capture();
		logic [7:0] es[3] = '{8'h02, 8'h01, 8'h03};
		logic [7:0] ex[3] = '{8'h03, 8'h03, 8'h00};
		do_reset();
		wr_reg(5'h13, 8'h02);
		wr_reg(5'h00, 8'h17);
		i_qtcp_pin_model.pulse_event(0, 5);
		repeat (6) @(posedge clk_i);
		rd_chk(5'h01, 8'h05);
		// capture select set only for this part
		wr_reg(5'h00, 8'h1f);
		for (int i = 0; i < 3; i++) begin
			wr_reg(5'h14, es[i]);
			i_qtcp_pin_model.pulse_capture(0);
			i_qtcp_pin_model.pulse_event(0, 3);
			i_qtcp_pin_model.pulse_capture(0);
			rd_chk(5'h01, ex[i]);
			rd_chk(5'h02, ex[i]);
		end
		rd_chk(5'h15, 8'h10);
		$display("test event_capture done");
	endtask

	task automatic t_paired();
		do_reset();
		wr_reg(5'h13, 8'h02);
		wr_reg(5'h03, 8'h01);
		wr_reg(5'h07, 8'h01);
		// odd select and pairing bits set
		wr_reg(5'h04, 8'h33);
		wr_reg(5'h00, 8'h17);
		i_qtcp_pin_model.pulse_event(0, 257);
		repeat (6) @(posedge clk_i);
		rd_chk(5'h01, 8'h01);
		rd_chk(5'h05, 8'h01);
		rd_chk(5'h15, 8'h00);
		i_qtcp_pin_model.pulse_event(0, 1);
		repeat (6) @(posedge clk_i);
		rd_chk(5'h15, 8'h01);
		rd_chk(5'h01, 8'h00);
		$display("test paired done");
	endtask

	task automatic t_compare();
		int hi;
		int per;
		do_reset();
		// pin function on, PWM left off
		wr_reg(5'h13, 8'h01);
		wr_reg(5'h0b, 8'h01);
		wr_reg(5'h08, 8'h10);
		i_qtcp_pin_model.measure(hi, per);
		check(hi, 4);
		check(per, 8);
		check({31'h0, oe_n}, 32'h0);
		$display("test compare done");
	endtask

	task automatic t_pwm();
		int hi;
		int per;
		logic [7:0] du[3] = '{8'h04, 8'h00, 8'h00};
		logic [7:0] md[3] = '{8'hd0, 8'hd0, 8'h50};
		logic ex[3] = '{1'b1, 1'b0, 1'b1};
		do_reset();
		// stopped, period and duty loaded before enabling
		wr_reg(5'h10, 8'h04);
		wr_reg(5'h11, 8'h01);
		wr_reg(5'h0c, 8'hc0);
		wr_reg(5'h13, 8'h01);
		wr_reg(5'h0c, 8'hd0);
		i_qtcp_pin_model.measure(hi, per);
		check(hi, 2);
		check(per, 5);
		for (int i = 0; i < 3; i++) begin
			wr_reg(5'h11, du[i]);
			wr_reg(5'h0c, md[i]);
			repeat (15) @(posedge clk_i);
			repeat (10) begin
				@(posedge clk_i);
				check({31'h0, pin}, {31'h0, ex[i]});
			end
		end
		$display("test pwm done");
	endtask

	initial begin
		t_reset_values();
		t_match();
		t_event_capture();
		t_paired();
		t_compare();
		t_pwm();
		complete_run();
	end

	// Whole-run guard against a hang
	initial begin
		#400000;
		err_count++;
		complete_run();
	end
endmodule

// ==== include/qtcp_pkg.sv ====
// Contract
// - Count advances per selected prescaled clock
// - Count from zero, match clears, sets flag
// - Timer 0 count and data share one address
// - Event source counts rising pin edges
// - Only timers 0 and 2 count events
// - Paired pair counts 16 bits, even flag only
// - Capture mode keeps match reset and flag
// - Capture edge copies count, then clears it
// - Edge select falling, rising, both; sets flag
// - Shared read gives capture or count; writes data
// - Paired capture works on the 16-bit count
// - Compare match toggles the output pin
// - Pin function plus enable gives 10-bit PWM
// - Period and duty are 10-bit values plus one
// - Duty buffered, reloaded at period match
// - Polarity sets level at full and zero duty
package qtcp_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int PRE_W = 11;
	// Timer block: address[4]=0, timer in [3:2], offset in [1:0]
	localparam logic [1:0] OFF_MODE = 2'h0;
	localparam logic [1:0] OFF_CNT = 2'h1;
	localparam logic [1:0] OFF_CAP = 2'h2;
	localparam logic [1:0] OFF_DATA = 2'h3;
	localparam logic [4:0] OFF_PWM_PER = 5'h10;
	localparam logic [4:0] OFF_PWM_DUTY = 5'h11;
	localparam logic [4:0] OFF_PWM_HI = 5'h12;
	localparam logic [4:0] OFF_PORT_FUNC = 5'h13;
	localparam logic [4:0] OFF_EDGE_SEL = 5'h14;
	localparam logic [4:0] OFF_FLAGS = 5'h15;
	// Mode register fields
	localparam int MB_CAP = 3;
	localparam int MB_RUN = 4;
	localparam int MB_PAIR = 5;
	localparam int MB_PWM_EN = 6;
	localparam int MB_POL = 7;
	localparam logic [2:0] CK_EVENT = 3'h7;
	// Port function, edge select and high-bits fields
	localparam int PF_PWM = 0;
	localparam int PF_EV0 = 1;
	localparam int ES_FALL = 0;
	localparam int ES_RISE = 1;
	localparam int HI_PER_LSB = 2;
	localparam int HI_DUTY_LSB = 0;
	localparam int FL_EXT_LSB = 4;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'hff;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] PER_RST = 8'hff;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [3:0] HI_RST = 4'h0;
	localparam logic [2:0] PF_RST = 3'h0;
	localparam logic [7:0] ES_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;

	// Prescaler mask for the even timers: ratios 2..2048
	function automatic logic [PRE_W-1:0] even_mask(input logic [2:0] s);
		case (s)
			3'h0: even_mask = 11'h001;
			3'h1: even_mask = 11'h003;
			3'h2: even_mask = 11'h007;
			3'h3: even_mask = 11'h01f;
			3'h4: even_mask = 11'h07f;
			3'h5: even_mask = 11'h1ff;
			3'h6: even_mask = 11'h7ff;
			default: even_mask = 11'h000;
		endcase
	endfunction

	// Prescaler mask for the odd timers: ratios 1, 2, 8 (code 3 as 8)
	function automatic logic [PRE_W-1:0] odd_mask(input logic [1:0] s);
		case (s)
			2'h0: odd_mask = 11'h000;
			2'h1: odd_mask = 11'h001;
			default: odd_mask = 11'h007;
		endcase
	endfunction
endpackage
